// File: rtl/dsp_status_pkg.sv
package dsp_status_pkg;

  // ********************************************************
  // register selection and layout
  // ********************************************************
  localparam logic SEL_ONE = 1'b0;
  localparam logic SEL_TWO = 1'b1;
  localparam int REG_W = 16;
  localparam int POS_W = 4;

  // status_reg_one fields
  localparam int SIGN_EXT_BIT = 8;
  localparam int WIDE_ACC_BIT = 10;
  localparam int EXT_FLAG_BIT = 13;
  localparam logic [15:0] ONE_MASK = 16'h2500;
  localparam logic [15:0] ONE_RESET = 16'h2100;

  // status_reg_two fields
  localparam int PTR_CIRC_LSB = 0;
  localparam int PTR_COUNT = 8;
  localparam int COEF_CIRC_BIT = 8;
  localparam int DEBUG_BLOCK_BIT = 12;
  localparam int PTR_MODE_BIT = 15;
  localparam logic [15:0] TWO_MASK = 16'h91ff;
  localparam logic [15:0] TWO_RESET = 16'h1000;
  localparam logic [15:0] DEBUG_MASK = 16'h1000;

  // ********************************************************
  // datapath widths
  // ********************************************************
  localparam int ACC_W = 40;
  localparam int LOW_W = 32;
  localparam int HALF_W = 16;
  localparam int GUARD_W = 8;
  localparam int DUAL_W = 24;
  localparam int MAC_W = 17;
  localparam int AMT_W = 6;
  localparam int SUBC_ALIGN = 15;

  // ********************************************************
  // operation kinds
  // ********************************************************
  typedef enum logic [2:0] {
    OPND_ARITH40 = 3'h0,
    OPND_LOGIC = 3'h1,
    OPND_DUAL_HI = 3'h3,
    OPND_PLAIN16 = 3'h2
  } opnd_kind_e;

  typedef enum logic [1:0] {
    SHIFT_SIGNED = 2'h0,
    SHIFT_LOGICAL = 2'h1,
    SHIFT_DUAL = 2'h3
  } shift_kind_e;

  // single-bit set or clear request
  typedef struct packed {
    logic valid;
    logic set;
    logic sel;
    logic [3:0] pos;
  } bit_op_s;

  // flow events that touch the status words
  typedef struct packed {
    logic hw_int;
    logic soft_int;
    logic trap;
    logic sw_reset;
    logic reti;
  } flow_evt_s;

endpackage

// File: rtl/dsp_status_bits.sv
// Function
// - sign_ext_mode is bit 8 of status_reg_one, read/write, reset 1.
// - wide_acc_mode bit 10 selects 32-bit (0) or 40-bit (1) D-unit ops.
// - sign_ext_mode 0 zero-extends short operands to 40 bits.
// - sign_ext_mode 1 sign-extends short operands to 40 bits.
// - dual mode upper-part values extend to 24 bits per sign_ext_mode.
// - dual mode right-shifted halves take sign or zero fill.
// - signed 32-bit shift fills guard bits 39-32 with bit 31 or zero.
// - signed right shift fill follows sign_ext_mode, unsigned gives zero.
// - conditional subtract correct for any 16-bit divisor when mode off.
// - logic, rotate, logical shift always zero-extend to 40 bits.
// - multiply-accumulate inputs sign-extend 16 to 17 bits unless unsigned-qualified, then zero.
// - unsigned-qualified operands are unsigned, overriding sign_ext_mode.
// - ext_flag_out bit 13, reset 1, drives the flag pin level.
// - eight ptr_circ_cfg bits at bit n, reset 0, 1 means circular.
// - ptr_mode_switch bit 15, reset 0, selects DSP or control mode.
// - control mode allows short offset; extended ones never issue paired.
// - coef_ptr_circ_cfg bit 8, reset 0, 1 means circular pointer.
// - debug_block bit 12 reset 1 blocks emulator, hw breakpoints, halts.
// - debug_block changes only through single-bit set and clear, entry events and return; word writes keep it.
// - interrupt, soft int, trap or reset entry pushes status_reg_two.
// - interrupt, soft int, reset entry set debug_block; trap does not.
// - return from interrupt reloads debug_block from the stacked word.
module dsp_status_bits (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  // single-bit set and clear
  input wire dsp_status_pkg::bit_op_s BIT_OP_IN,
  // whole-word register write
  input wire logic REG_WR_IN,
  input wire logic REG_SEL_IN,
  input wire logic [15:0] REG_WDATA_IN,
  // program flow events
  input wire dsp_status_pkg::flow_evt_s FLOW_IN,
  input wire logic [15:0] STACK_TWO_IN,
  // operand extension
  input wire logic [15:0] OPND_IN,
  input wire dsp_status_pkg::opnd_kind_e OPND_KIND_IN,
  input wire logic OPND_UNS_IN,
  // accumulator shifter and conditional subtract
  input wire logic [39:0] ACC_IN,
  input wire logic [5:0] SHIFT_AMT_IN,
  input wire logic SHIFT_LEFT_IN,
  input wire dsp_status_pkg::shift_kind_e SHIFT_KIND_IN,
  input wire logic ACC_UNS_IN,
  // issue and debug requests
  input wire logic PAR_REQ_IN,
  input wire logic OFS_EXT_IN,
  input wire logic EMU_REQ_IN,
  input wire logic HW_BKPT_IN,
  input wire logic HALT_REQ_IN,
  input wire logic SW_BKPT_IN,
  // register read back
  output logic [15:0] STATUS_ONE_OUT,
  output logic [15:0] STATUS_TWO_OUT,
  // stack push
  output logic PUSH_VALID_OUT,
  output logic [15:0] PUSH_DATA_OUT,
  // mode outputs
  output logic EXT_FLAG_OUT,
  output logic SIGN_EXT_OUT,
  output logic WIDE_ACC_OUT,
  output logic [7:0] PTR_CIRC_OUT,
  output logic COEF_CIRC_OUT,
  output logic REV_CARRY_EN_OUT,
  output logic SHORT_OFS_EN_OUT,
  output logic DEBUG_BLOCK_OUT,
  // datapath results
  output logic [39:0] OPND_EXT_OUT,
  output logic [16:0] MAC_OPND_OUT,
  output logic [39:0] SHIFT_OUT,
  output logic [39:0] SUBC_OUT,
  // issue and debug answers
  output logic PAR_GRANT_OUT,
  output logic EMU_GRANT_OUT,
  output logic HALT_OUT
);

  // ********************************************************
  // helpers
  // ********************************************************

  // fill bit of a short operand: sign only when enabled and signed
  function automatic logic fill_of(input logic msb, input logic sxm,
                                   input logic uns);
    fill_of = msb & sxm & ~uns;
  endfunction

  // right shift of a left-justified value with a chosen fill bit
  function automatic logic [39:0] shr_fill(input logic [39:0] v,
                                           input logic [5:0] a,
                                           input logic f);
    logic [39:0] ones;
    ones = {40{1'b1}};
    shr_fill = f ? ((v >> a) | ~(ones >> a)) : (v >> a);
  endfunction

  // ********************************************************
  // status words
  // ********************************************************
  logic [15:0] status_reg_one;
  logic [15:0] status_reg_two;
  logic [15:0] next_one;
  logic [15:0] next_two;
  logic sxm;
  logic m40;
  logic dbg;
  logic entry_evt;
  logic block_evt;

  assign sxm = status_reg_one[dsp_status_pkg::SIGN_EXT_BIT];
  assign m40 = status_reg_one[dsp_status_pkg::WIDE_ACC_BIT];
  assign dbg = status_reg_two[dsp_status_pkg::DEBUG_BLOCK_BIT];

  // entry events that save status_reg_two
  // entry pushes word
  assign entry_evt = FLOW_IN.hw_int | FLOW_IN.soft_int | FLOW_IN.trap |
                     FLOW_IN.sw_reset;
  assign block_evt = FLOW_IN.hw_int | FLOW_IN.soft_int | FLOW_IN.sw_reset;

  // next value of status_reg_one
  always_comb begin
    next_one = status_reg_one;
    if (REG_WR_IN && REG_SEL_IN == dsp_status_pkg::SEL_ONE) begin
      next_one = REG_WDATA_IN;
    end
    if (BIT_OP_IN.valid && BIT_OP_IN.sel == dsp_status_pkg::SEL_ONE) begin
      next_one[BIT_OP_IN.pos] = BIT_OP_IN.set;
    end
    next_one = next_one & dsp_status_pkg::ONE_MASK;
  end

  // next value of status_reg_two
  always_comb begin
    next_two = status_reg_two;
    if (REG_WR_IN && REG_SEL_IN == dsp_status_pkg::SEL_TWO) begin
      next_two = (REG_WDATA_IN & ~dsp_status_pkg::DEBUG_MASK) |
                 (status_reg_two & dsp_status_pkg::DEBUG_MASK);
    end
    if (BIT_OP_IN.valid && BIT_OP_IN.sel == dsp_status_pkg::SEL_TWO) begin
      next_two[BIT_OP_IN.pos] = BIT_OP_IN.set;
    end
    if (FLOW_IN.reti) begin
      next_two = STACK_TWO_IN;
    end
    if (block_evt) begin
      next_two[dsp_status_pkg::DEBUG_BLOCK_BIT] = 1'b1;
    end
    next_two = next_two & dsp_status_pkg::TWO_MASK;
  end

  // status_reg_one storage
  // sign extension resets on
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      status_reg_one <= dsp_status_pkg::ONE_RESET;
    end else begin
      status_reg_one <= next_one;
    end
  end

  // status_reg_two storage
  // debug_block resets set
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      status_reg_two <= dsp_status_pkg::TWO_RESET;
    end else begin
      status_reg_two <= next_two;
    end
  end

  // ********************************************************
  // read back and mode outputs
  // ********************************************************

  // registered copies of the status words and their fields
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      STATUS_ONE_OUT <= dsp_status_pkg::ONE_RESET;
      STATUS_TWO_OUT <= dsp_status_pkg::TWO_RESET;
    end else begin
      STATUS_ONE_OUT <= next_one;
      STATUS_TWO_OUT <= next_two;
    end
  end

  // mode bits follow the stored words in the same edge
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      EXT_FLAG_OUT <= dsp_status_pkg::ONE_RESET[dsp_status_pkg::EXT_FLAG_BIT];
      SIGN_EXT_OUT <= dsp_status_pkg::ONE_RESET[dsp_status_pkg::SIGN_EXT_BIT];
      WIDE_ACC_OUT <= dsp_status_pkg::ONE_RESET[dsp_status_pkg::WIDE_ACC_BIT];
      PTR_CIRC_OUT <= dsp_status_pkg::TWO_RESET[7:0];
      COEF_CIRC_OUT <=
        dsp_status_pkg::TWO_RESET[dsp_status_pkg::COEF_CIRC_BIT];
      REV_CARRY_EN_OUT <=
        ~dsp_status_pkg::TWO_RESET[dsp_status_pkg::PTR_MODE_BIT];
      SHORT_OFS_EN_OUT <=
        dsp_status_pkg::TWO_RESET[dsp_status_pkg::PTR_MODE_BIT];
      DEBUG_BLOCK_OUT <=
        dsp_status_pkg::TWO_RESET[dsp_status_pkg::DEBUG_BLOCK_BIT];
    end else begin
      EXT_FLAG_OUT <= next_one[dsp_status_pkg::EXT_FLAG_BIT];
      SIGN_EXT_OUT <= next_one[dsp_status_pkg::SIGN_EXT_BIT];
      WIDE_ACC_OUT <= next_one[dsp_status_pkg::WIDE_ACC_BIT];
      PTR_CIRC_OUT <= next_two[dsp_status_pkg::PTR_CIRC_LSB +:
                               dsp_status_pkg::PTR_COUNT];
      COEF_CIRC_OUT <= next_two[dsp_status_pkg::COEF_CIRC_BIT];
      REV_CARRY_EN_OUT <= ~next_two[dsp_status_pkg::PTR_MODE_BIT];
      SHORT_OFS_EN_OUT <= next_two[dsp_status_pkg::PTR_MODE_BIT];
      DEBUG_BLOCK_OUT <= next_two[dsp_status_pkg::DEBUG_BLOCK_BIT];
    end
  end

  // ********************************************************
  // stack push
  // ********************************************************

  // the word saved is the one before entry changes it
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      PUSH_VALID_OUT <= 1'b0;
      PUSH_DATA_OUT <= 16'h0000;
    end else begin
      PUSH_VALID_OUT <= entry_evt;
      PUSH_DATA_OUT <= entry_evt ? status_reg_two : PUSH_DATA_OUT;
    end
  end

  // ********************************************************
  // operand extension
  // ********************************************************
  logic [39:0] next_opnd;
  logic [16:0] next_mac;
  logic opnd_fill;

  assign opnd_fill = fill_of(OPND_IN[15], sxm, OPND_UNS_IN);

  // extension by operation kind
  always_comb begin
    next_opnd = {{24{1'b0}}, OPND_IN};
    case (OPND_KIND_IN)
      dsp_status_pkg::OPND_ARITH40: begin
        next_opnd = {{24{opnd_fill}}, OPND_IN};
      end
      dsp_status_pkg::OPND_LOGIC: begin
        next_opnd = {{24{1'b0}}, OPND_IN};
      end
      dsp_status_pkg::OPND_DUAL_HI: begin
        next_opnd = {{8{opnd_fill}}, OPND_IN, 16'h0000};
      end
      default: begin
        next_opnd = {{24{1'b0}}, OPND_IN};
      end
    endcase
  end

  // multiply-accumulate input ignores sign_ext_mode
  // sign to 17 bits
  assign next_mac = {OPND_IN[15] & ~OPND_UNS_IN, OPND_IN};

  // registered operand results
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      OPND_EXT_OUT <= 40'h00_0000_0000;
      MAC_OPND_OUT <= 17'h0_0000;
    end else begin
      OPND_EXT_OUT <= next_opnd;
      MAC_OPND_OUT <= next_mac;
    end
  end

  // ********************************************************
  // accumulator shifter
  // ********************************************************
  logic [39:0] next_shift;
  logic [39:0] sh40;
  logic [31:0] sh32;
  logic [15:0] sh_hi;
  logic [15:0] sh_lo;
  logic [39:0] sh_tmp;
  logic f40;
  logic f32;
  logic f_hi;
  logic f_lo;

  // fill bits for the three widths
  // fill follows mode and qualifier
  assign f40 = fill_of(ACC_IN[39], sxm, ACC_UNS_IN);
  assign f32 = fill_of(ACC_IN[31], sxm, ACC_UNS_IN);
  assign f_hi = fill_of(ACC_IN[31], sxm, ACC_UNS_IN);
  assign f_lo = fill_of(ACC_IN[15], sxm, ACC_UNS_IN);

  // shift by width and kind
  always_comb begin
    sh40 = ACC_IN;
    sh32 = ACC_IN[31:0];
    sh_hi = ACC_IN[31:16];
    sh_lo = ACC_IN[15:0];
    sh_tmp = ACC_IN;
    next_shift = ACC_IN;
    case (SHIFT_KIND_IN)
      dsp_status_pkg::SHIFT_SIGNED: begin
        if (SHIFT_LEFT_IN) begin
          sh40 = ACC_IN << SHIFT_AMT_IN;
        end else begin
          sh40 = shr_fill(ACC_IN, SHIFT_AMT_IN, f40);
        end
        sh_tmp = shr_fill({ACC_IN[31:0], 8'h00}, SHIFT_AMT_IN, f32);
        if (!SHIFT_LEFT_IN) begin
          sh32 = sh_tmp[39:8];
        end else begin
          sh32 = ACC_IN[31:0] << SHIFT_AMT_IN;
        end
        next_shift = m40 ? sh40 : {{8{sxm & sh32[31]}}, sh32};
      end
      dsp_status_pkg::SHIFT_LOGICAL: begin
        if (SHIFT_LEFT_IN) begin
          sh40 = ACC_IN << SHIFT_AMT_IN;
          sh32 = ACC_IN[31:0] << SHIFT_AMT_IN;
        end else begin
          sh40 = ACC_IN >> SHIFT_AMT_IN;
          sh32 = ACC_IN[31:0] >> SHIFT_AMT_IN;
        end
        next_shift = m40 ? sh40 : {8'h00, sh32};
      end
      dsp_status_pkg::SHIFT_DUAL: begin
        sh_tmp = shr_fill({ACC_IN[31:16], 24'h00_0000}, SHIFT_AMT_IN, f_hi);
        sh_hi = sh_tmp[39:24];
        sh_tmp = shr_fill({ACC_IN[15:0], 24'h00_0000}, SHIFT_AMT_IN, f_lo);
        sh_lo = sh_tmp[39:24];
        next_shift = {{8{f_hi}}, sh_hi, sh_lo};
      end
      default: begin
        next_shift = ACC_IN;
      end
    endcase
  end

  // registered shift result
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      SHIFT_OUT <= 40'h00_0000_0000;
    end else begin
      SHIFT_OUT <= next_shift;
    end
  end

  // ********************************************************
  // conditional subtract step
  // ********************************************************
  logic [39:0] divisor;
  logic [39:0] diff;
  logic [39:0] next_subc;

  // divisor fill follows sign_ext_mode; zero fill keeps top-bit divisors correct
  assign divisor = {{24{opnd_fill}}, OPND_IN} << dsp_status_pkg::SUBC_ALIGN;
  assign diff = ACC_IN - divisor;

  // keep difference when non-negative, then shift in the quotient bit
  always_comb begin
    if (!diff[39]) begin
      next_subc = {diff[38:0], 1'b1};
    end else begin
      next_subc = {ACC_IN[38:0], 1'b0};
    end
  end

  // registered subtract result
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      SUBC_OUT <= 40'h00_0000_0000;
    end else begin
      SUBC_OUT <= next_subc;
    end
  end

  // ********************************************************
  // issue and debug gating
  // ********************************************************

  // paired issue refused for extended-offset instructions
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      PAR_GRANT_OUT <= 1'b0;
    end else begin
      PAR_GRANT_OUT <= PAR_REQ_IN & ~OFS_EXT_IN;
    end
  end

  // emulator and halt gating by debug_block
  always_ff @(posedge CLK_IN) begin
    if (SYS_RST_IN) begin
      EMU_GRANT_OUT <= 1'b0;
      HALT_OUT <= 1'b0;
    end else begin
      EMU_GRANT_OUT <= EMU_REQ_IN & ~dbg;
      HALT_OUT <= SW_BKPT_IN | (~dbg & (HW_BKPT_IN | HALT_REQ_IN));
    end
  end

endmodule

// File: dv/dsp_status_asserts.sv
module dsp_status_asserts (
  // clock and reset
  input wire logic CLK_IN,
  input wire logic SYS_RST_IN,
  // requests
  input wire dsp_status_pkg::bit_op_s BIT_OP_IN,
  input wire logic REG_WR_IN,
  input wire dsp_status_pkg::flow_evt_s FLOW_IN,
  input wire logic [15:0] STACK_TWO_IN,
  input wire logic [15:0] OPND_IN,
  input wire logic OPND_UNS_IN,
  // answers
  input wire logic [15:0] STATUS_ONE_OUT,
  input wire logic [15:0] STATUS_TWO_OUT,
  input wire logic PUSH_VALID_OUT,
  input wire logic [15:0] PUSH_DATA_OUT,
  input wire logic EXT_FLAG_OUT,
  input wire logic REV_CARRY_EN_OUT,
  input wire logic SHORT_OFS_EN_OUT,
  input wire logic DEBUG_BLOCK_OUT,
  input wire logic [16:0] MAC_OPND_OUT
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge CLK_IN); endclocking
  default disable iff (SYS_RST_IN);
  logic dbg_op;
  logic mac_fill;
  logic [15:0] op_mask;
  // helpers: debug bit addressed, mac fill, addressed bit
  assign dbg_op = BIT_OP_IN.valid && BIT_OP_IN.sel && BIT_OP_IN.pos == 4'hc;
  assign mac_fill = OPND_IN[15] & ~OPND_UNS_IN;
  assign op_mask = 16'h1 << BIT_OP_IN.pos;
  // interrupt-like entries that raise the debug block
  sequence entry_s;
    FLOW_IN.hw_int || FLOW_IN.soft_int || FLOW_IN.sw_reset;
  endsequence
  // push of the word held before the event
  sequence push_s;
    PUSH_VALID_OUT && PUSH_DATA_OUT == $past(STATUS_TWO_OUT);
  endsequence
  reset_words_a: assert property ($past(SYS_RST_IN) |->
    STATUS_ONE_OUT == 16'h2100 && STATUS_TWO_OUT == 16'h1000)
    else $error("status words wrong after reset");
  flag_pin_a: assert property (EXT_FLAG_OUT == STATUS_ONE_OUT[13])
    else $error("flag pin differs from its bit");
  ptr_mode_a: assert property (SHORT_OFS_EN_OUT == STATUS_TWO_OUT[15]
    && REV_CARRY_EN_OUT != STATUS_TWO_OUT[15])
    else $error("pointer mode outputs wrong");
  debug_hold_a: assert property (!dbg_op && FLOW_IN == 5'h0
    |=> $stable(DEBUG_BLOCK_OUT))
    else $error("debug block changed without a bit op");
  entry_push_a: assert property ((entry_s or FLOW_IN.trap) |=>
    push_s)
    else $error("status word not pushed on entry");
  entry_debug_a: assert property (entry_s |=> DEBUG_BLOCK_OUT)
    else $error("debug block not set on entry");
  trap_debug_a: assert property (FLOW_IN == 5'h04 && !dbg_op
    |=> DEBUG_BLOCK_OUT == $past(DEBUG_BLOCK_OUT))
    else $error("trap changed debug block");
  reti_load_a: assert property (FLOW_IN == 5'h01 && !BIT_OP_IN.valid
    |=> STATUS_TWO_OUT == ($past(STACK_TWO_IN) & 16'h91ff))
    else $error("return did not reload status two");
  mac_ext_a: assert property (1'b1 |=>
    MAC_OPND_OUT == {$past(mac_fill), $past(OPND_IN)})
    else $error("mac operand extension wrong");
  bit_single_a: assert property (BIT_OP_IN.valid && !BIT_OP_IN.sel
    && !REG_WR_IN |=> ((STATUS_ONE_OUT ^ $past(STATUS_ONE_OUT))
    & ~$past(op_mask)) == 16'h0)
    else $error("bit op touched another bit");
endmodule

bind dsp_status_bits dsp_status_asserts u_chk (.CLK_IN, .SYS_RST_IN,
  .BIT_OP_IN, .REG_WR_IN, .FLOW_IN, .STACK_TWO_IN, .OPND_IN, .OPND_UNS_IN,
  .STATUS_ONE_OUT, .STATUS_TWO_OUT, .PUSH_VALID_OUT, .PUSH_DATA_OUT,
  .EXT_FLAG_OUT, .REV_CARRY_EN_OUT, .SHORT_OFS_EN_OUT, .DEBUG_BLOCK_OUT,
  .MAC_OPND_OUT);

// File: dv/data_stack_model.sv
module data_stack_model (
  // clock and reset
  input wire logic clk_in,
  input wire logic rst_in,
  // pushes from the block, pops on return
  input wire logic push_in,
  input wire logic [15:0] push_data_in,
  input wire logic pop_in,
  // popped word, meaningful only while pop_in is high
  output logic [15:0] top_out
);
  timeunit 1ns;
  timeprecision 100ps;
  logic [15:0] mem [0:15];
  logic [3:0] sp;
  logic [15:0] junk;
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      sp <= 4'h0;
    end else if (push_in) begin
      mem[sp] <= push_data_in;
      sp <= sp + 4'h1;
    end else if (pop_in) begin
      sp <= sp - 4'h1;
    end
  end
  // changing pattern so an idle line never looks valid
  always_ff @(posedge clk_in) begin
    junk <= rst_in ? 16'h5a5a : junk + 16'h3b1d;
  end
  assign top_out = pop_in ? mem[sp - 4'h1] : junk;
endmodule

// File: dv/testbench.sv
module testbench;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk, rst, wr_en, wr_sel, ouns, sleft, auns, f;
  logic par_req, ofs_ext, emu_req, hw_bkpt, halt_req, sw_bkpt;
  logic pv, xf, sx, wa, cc, rc, so, db, pg, eg, ho;
  logic [15:0] wr_data, opnd, s1, s2, pd, top, e1, e2, m;
  logic [39:0] acc, ox, sh, sc, ex;
  logic [5:0] amt;
  logic [16:0] mo;
  logic [7:0] pc;
  logic [4:0] kinds [0:3] = '{5'h10, 5'h08, 5'h02, 5'h04};
  dsp_status_pkg::bit_op_s bop;
  dsp_status_pkg::flow_evt_s flow;
  dsp_status_pkg::opnd_kind_e okind;
  dsp_status_pkg::shift_kind_e skind;
  int n_mismatch, compares, cyc = 0;

  dsp_status_bits dut (.CLK_IN(clk), .SYS_RST_IN(rst), .BIT_OP_IN(bop),
    .REG_WR_IN(wr_en), .REG_SEL_IN(wr_sel), .REG_WDATA_IN(wr_data),
    .FLOW_IN(flow), .STACK_TWO_IN(top), .OPND_IN(opnd), .OPND_KIND_IN(okind),
    .OPND_UNS_IN(ouns), .ACC_IN(acc), .SHIFT_AMT_IN(amt),
    .SHIFT_LEFT_IN(sleft), .SHIFT_KIND_IN(skind), .ACC_UNS_IN(auns),
    .PAR_REQ_IN(par_req), .OFS_EXT_IN(ofs_ext), .EMU_REQ_IN(emu_req),
    .HW_BKPT_IN(hw_bkpt), .HALT_REQ_IN(halt_req), .SW_BKPT_IN(sw_bkpt),
    .STATUS_ONE_OUT(s1), .STATUS_TWO_OUT(s2), .PUSH_VALID_OUT(pv),
    .PUSH_DATA_OUT(pd), .EXT_FLAG_OUT(xf), .SIGN_EXT_OUT(sx),
    .WIDE_ACC_OUT(wa), .PTR_CIRC_OUT(pc), .COEF_CIRC_OUT(cc),
    .REV_CARRY_EN_OUT(rc), .SHORT_OFS_EN_OUT(so), .DEBUG_BLOCK_OUT(db),
    .OPND_EXT_OUT(ox), .MAC_OPND_OUT(mo), .SHIFT_OUT(sh), .SUBC_OUT(sc),
    .PAR_GRANT_OUT(pg), .EMU_GRANT_OUT(eg), .HALT_OUT(ho));

  data_stack_model stack (.clk_in(clk), .rst_in(rst), .push_in(pv),
    .push_data_in(pd), .pop_in(flow.reti), .top_out(top));

  // ************************************************
  // clock, watchdog and shared tasks
  // ************************************************
  initial begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end
  // cut a hung run short
  always @(posedge clk) begin
    cyc++;
    if (cyc == 3000) begin
      n_mismatch++;
      close_out;
    end
  end
  task tick;
    @(posedge clk);
    #1;
  endtask
  task check(input string name, input logic [39:0] seen, exp);
    compares++;
    if (seen !== exp) begin
      $display("wrong value %s expected %h seen %h", name, exp, seen);
      n_mismatch++;
    end
  endtask
  task close_out;
    if (n_mismatch == 0 && compares > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  task mirrors;
    check("mode bits", {xf, sx, wa, pc, cc, db, so, rc}, {e1[13], e1[8],
      e1[10], e2[7:0], e2[8], e2[12], e2[15], ~e2[15]});
  endtask
  task bit_op(input logic sel, set, input logic [3:0] pos);
    bop = {1'b1, set, sel, pos};
    tick;
    bop = '0;
    tick;
  endtask
  task wr(input logic sel, input logic [15:0] d);
    wr_en = 1'b1;
    wr_sel = sel;
    wr_data = d;
    tick;
    wr_en = 1'b0;
    tick;
  endtask
  task ev(input logic [4:0] fv, input logic dbg);
    flow = fv;
    tick;
    flow = '0;
    check("push valid", pv, |fv[4:1]);
    if (|fv[4:1]) check("push data", pd, 16'h0003);
    check("debug", db, dbg);
    tick;
    check("push end", pv, 1'b0);
  endtask
  task shf(input logic sxm, m40, uns, input logic [1:0] k,
    input logic left, input logic [39:0] a, input logic [5:0] n,
    input logic [39:0] e);
    wr(1'b0, {5'h0, m40, 1'b0, sxm, 8'h0});
    acc = a;
    skind = dsp_status_pkg::shift_kind_e'(k);
    sleft = left;
    auns = uns;
    amt = n;
    tick;
    check("shift", sh, e);
  endtask

  // main sequence
  initial begin
    rst = 1'b1;
    bop = '0;
    {wr_en, wr_sel, wr_data, flow, opnd, ouns} = '0;
    {acc, amt, sleft, auns, par_req, ofs_ext} = '0;
    {emu_req, hw_bkpt, halt_req, sw_bkpt} = 4'h0;
    okind = dsp_status_pkg::OPND_ARITH40;
    skind = dsp_status_pkg::SHIFT_SIGNED;
    n_mismatch = 0;
    compares = 0;
    repeat (3) @(posedge clk);
    #1 rst = 1'b0;
    tick;
    e1 = 16'h2100;
    e2 = 16'h1000;
    check("status one", s1, e1);
    check("status two", s2, e2);
    mirrors;
    for (int s = 0; s < 2; s++) begin
      for (int v = 1; v >= 0; v--) begin
        for (int p = 0; p < 16; p++) begin
          m = (s ? 16'h91ff : 16'h2500) & (16'h1 << p);
          if (s) e2 = v ? (e2 | m) : (e2 & ~m);
          else e1 = v ? (e1 | m) : (e1 & ~m);
          bit_op(s[0], v[0], p[3:0]);
          check("status one", s1, e1);
          check("status two", s2, e2);
          mirrors;
        end
      end
    end
    wr(1'b0, 16'hffff);
    check("status one", s1, 16'h2500);
    wr(1'b1, 16'hffff);
    check("status two", s2, 16'h81ff);
    bit_op(1'b1, 1'b1, 4'hc);
    wr(1'b1, 16'h0003);
    check("status two", s2, 16'h1003);
    for (int k = 0; k < 4; k++) begin
      bit_op(1'b1, 1'b0, 4'hc);
      ev(kinds[k], k < 3);
    end
    wr(1'b1, 16'h0000);
    ev(5'h01, 1'b0);
    check("status two", s2, 16'h0003);
    bit_op(1'b1, 1'b1, 4'hc);
    ev(5'h01, 1'b0);
    for (int d = 0; d < 2; d++) begin
      if (d) bit_op(1'b1, 1'b1, 4'hc);
      for (int i = 0; i < 64; i++) begin
        {par_req, ofs_ext, emu_req, hw_bkpt, halt_req, sw_bkpt} = i[5:0];
        tick;
        check("halt", ho, sw_bkpt | (!d[0] & (hw_bkpt | halt_req)));
        check("emulator", eg, emu_req & !d[0]);
        check("parallel", pg, par_req & !ofs_ext);
      end
    end
    for (int x = 0; x < 2; x++) begin
      wr(1'b0, {7'h0, x[0], 8'h0});
      for (int k = 0; k < 4; k++) begin
        for (int u = 0; u < 2; u++) begin
          opnd = 16'h8001;
          okind = dsp_status_pkg::opnd_kind_e'(k[2:0]);
          ouns = u[0];
          tick;
          f = x[0] & !u[0];
          ex = 40'h0000008001;
          if (k == 0) ex = {{24{f}}, 16'h8001};
          if (k == 3) ex = {{8{f}}, 16'h8001, 16'h0};
          check("operand", ox, ex);
          check("mac operand", mo, {!u[0], 16'h8001});
        end
      end
    end
    shf(1, 0, 0, 0, 0, 40'h0080000000, 4, 40'hfff8000000);
    shf(0, 0, 0, 0, 0, 40'h0080000000, 4, 40'h0008000000);
    shf(1, 0, 1, 0, 0, 40'h0080000000, 4, 40'h0008000000);
    shf(1, 1, 0, 0, 0, 40'h8000000000, 4, 40'hf800000000);
    shf(0, 1, 0, 0, 0, 40'h8000000000, 4, 40'h0800000000);
    shf(1, 1, 0, 1, 0, 40'h8000000000, 4, 40'h0800000000);
    shf(1, 0, 0, 3, 0, 40'h0080008000, 4, 40'hfff800f800);
    shf(0, 0, 0, 3, 0, 40'h0080008000, 4, 40'h0008000800);
    shf(1, 0, 0, 0, 1, 40'h0040000000, 1, 40'hff80000000);
    shf(0, 0, 0, 0, 1, 40'h0040000000, 1, 40'h0080000000);
    wr(1'b0, 16'h0000);
    opnd = 16'h8000;
    okind = dsp_status_pkg::OPND_ARITH40;
    ouns = 1'b0;
    acc = 40'h0040000000;
    tick;
    check("subtract", sc, 40'h0000000001);
    acc = 40'h003fffffff;
    tick;
    check("subtract", sc, 40'h007ffffffe);
    close_out;
  end
endmodule
